// *** dmma_pkg.sv ***
package dmma_pkg;
	localparam int ADDR_W         = 32;
	localparam int DATA_W         = 32;
	localparam int BE_W           = 4;
	localparam int MSB_POS        = 31;
	localparam int FIXED_RD_LAT   = 2;
	localparam logic [31:0] FIXED_BASE_DEF = 32'h0000_0000;
	localparam logic [31:0] FIXED_SIZE_DEF = 32'h0001_0000;
	localparam logic [31:0] THREAD_STRIDE_DEF = 32'h0000_1000;
	localparam logic [31:0] CTX_STRIDE_DEF    = 32'h0000_0400;
	localparam logic [31:0] CTX_BASE_DEF      = 32'h0010_0000;
	localparam logic [31:0] CTX_SIZE_DEF      = 32'h0010_0000;

	typedef enum logic [1:0] {
		DMMA_SZ_BYTE = 2'h0,
		DMMA_SZ_HALF = 2'h1,
		DMMA_SZ_WORD = 2'h2
	} dmma_size_t;

	typedef enum logic [1:0] {
		DMMA_IDLE  = 2'h0,
		DMMA_VWAIT = 2'h1
	} dmma_state_t;
endpackage

// *** dmma_core.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - All addresses are 32-bit byte addresses, 4 GB space.
// - Read and write data paths to memory are 32 bits wide.
// - Data accesses may be byte, half-word or word sized.
// - Fetches and data use separate masters; data never reaches instruction space.
// - Data address top bit is dropped; data lives in lower half.
// - Fetch address top bit is forced high by hardware.
// - Both data masters use big-endian byte-invariant lane order.
// - Effective data address is register value plus immediate offset.
// - All threads share the same two data and instruction masters.
// - Fixed-latency port returns read data exactly two cycles after request.
// - Address decode picks fixed-latency or variable-latency port automatically.
// - Optional thread partitioning adds a thread-based offset to data address.
// - Current thread and context identifier are exported on a side port.
module dmma_core #(
	parameter int THREAD_W = 3,
	parameter int CTX_W    = 6,
	parameter bit THREAD_PART = 1'b0,
	parameter bit CTX_PART    = 1'b0,
	parameter logic [31:0] FIXED_BASE    = dmma_pkg::FIXED_BASE_DEF,
	parameter logic [31:0] FIXED_SIZE    = dmma_pkg::FIXED_SIZE_DEF,
	parameter logic [31:0] THREAD_STRIDE = dmma_pkg::THREAD_STRIDE_DEF,
	parameter logic [31:0] CTX_BASE      = dmma_pkg::CTX_BASE_DEF,
	parameter logic [31:0] CTX_SIZE      = dmma_pkg::CTX_SIZE_DEF,
	parameter logic [31:0] CTX_STRIDE    = dmma_pkg::CTX_STRIDE_DEF
) (
	// Clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          reset_n_i,
	// Fetch request from the core
	input  wire logic                          if_req_i,
	input  wire logic [dmma_pkg::ADDR_W-1:0]   if_addr_i,
	output logic                               if_ready_o,
	output logic                               if_valid_o,
	output logic [dmma_pkg::DATA_W-1:0]        if_data_o,
	// Data request from the core
	input  wire logic                          ld_req_i,
	input  wire logic                          ld_write_i,
	input  wire logic [dmma_pkg::ADDR_W-1:0]   ld_base_i,
	input  wire logic [15:0]                   ld_imm_i,
	input  wire dmma_pkg::dmma_size_t          ld_size_i,
	input  wire logic [dmma_pkg::DATA_W-1:0]   ld_wdata_i,
	input  wire logic [THREAD_W-1:0]           ld_thread_i,
	input  wire logic [CTX_W-1:0]              ld_ctx_i,
	output logic                               ld_ready_o,
	output logic                               ld_valid_o,
	output logic [dmma_pkg::DATA_W-1:0]        ld_rdata_o,
	// Instruction master
	output logic                               im_read_o,
	output logic [dmma_pkg::ADDR_W-1:0]        im_address_o,
	input  wire logic                          im_waitrequest_i,
	input  wire logic                          im_readdatavalid_i,
	input  wire logic [dmma_pkg::DATA_W-1:0]   im_readdata_i,
	// Fixed-latency data master
	output logic                               fm_read_o,
	output logic                               fm_write_o,
	output logic [dmma_pkg::ADDR_W-1:0]        fm_address_o,
	output logic [dmma_pkg::BE_W-1:0]          fm_byteenable_o,
	output logic [dmma_pkg::DATA_W-1:0]        fm_writedata_o,
	input  wire logic [dmma_pkg::DATA_W-1:0]   fm_readdata_i,
	// Variable-latency data master
	output logic                               vm_read_o,
	output logic                               vm_write_o,
	output logic [dmma_pkg::ADDR_W-1:0]        vm_address_o,
	output logic [dmma_pkg::BE_W-1:0]          vm_byteenable_o,
	output logic [dmma_pkg::DATA_W-1:0]        vm_writedata_o,
	input  wire logic                          vm_waitrequest_i,
	input  wire logic                          vm_readdatavalid_i,
	input  wire logic [dmma_pkg::DATA_W-1:0]   vm_readdata_i,
	// Thread information side port
	output logic [THREAD_W-1:0]                ti_thread_o,
	output logic [CTX_W-1:0]                   ti_context_identifier_o,
	output logic                               ti_valid_o
);
	import dmma_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Fetch path: one outstanding fetch at a time

	logic if_busy;

	assign if_ready_o = !if_busy;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			if_busy      <= 1'b0;
			im_read_o    <= 1'b0;
			im_address_o <= 32'h0000_0000;
		end else if (!if_busy) begin
			if (if_req_i) begin
				if_busy      <= 1'b1;
				im_read_o    <= 1'b1;
				im_address_o <= {1'b1, if_addr_i[MSB_POS-1:0]};
			end
		end else begin
			if (im_read_o && !im_waitrequest_i) begin
				im_read_o <= 1'b0;
			end
			if (im_readdatavalid_i) begin
				if_busy <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			if_valid_o <= 1'b0;
			if_data_o  <= 32'h0000_0000;
		end else begin
			if_valid_o <= if_busy && im_readdatavalid_i;
			if (im_readdatavalid_i) begin
				if_data_o <= im_readdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data address: register plus immediate, top bit dropped, then partitioned

	logic [31:0] eff_addr;
	logic [31:0] data_addr;
	logic [31:0] phys_addr;
	logic        in_ctx;
	logic        to_fixed;

	assign eff_addr  = ld_base_i + {{16{ld_imm_i[15]}}, ld_imm_i};
	assign data_addr = {1'b0, eff_addr[MSB_POS-1:0]};
	assign in_ctx    = CTX_PART && (data_addr - CTX_BASE) < CTX_SIZE;

	// Offsets are added, not ORed, so regions need no power-of-two alignment
	always_comb begin
		phys_addr = data_addr;
		if (in_ctx) begin
			phys_addr = data_addr + 32'(ld_ctx_i) * CTX_STRIDE;
		end else if (THREAD_PART) begin
			phys_addr = data_addr + 32'(ld_thread_i) * THREAD_STRIDE;
		end
		phys_addr[MSB_POS] = 1'b0;
	end

	assign to_fixed = (phys_addr - FIXED_BASE) < FIXED_SIZE;

	////////////////////////////////////////////////////////////////////////////
	// Lane steering, big-endian byte-invariant

	logic [3:0]  lane_be;
	logic [31:0] lane_wdata;

	always_comb begin
		lane_be    = 4'h0;
		lane_wdata = ld_wdata_i;
		case (ld_size_i)
			DMMA_SZ_BYTE: begin
				lane_be    = 4'h8 >> phys_addr[1:0];
				lane_wdata = {4{ld_wdata_i[7:0]}};
			end
			DMMA_SZ_HALF: begin
				lane_be    = phys_addr[1] ? 4'h3 : 4'hC;
				lane_wdata = {2{ld_wdata_i[15:0]}};
			end
			DMMA_SZ_WORD: begin
				lane_be    = 4'hF;
				lane_wdata = ld_wdata_i;
			end
			default: begin
				lane_be    = 4'h0;
				lane_wdata = ld_wdata_i;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Data issue and return

	dmma_state_t state;
	logic        vm_pend;
	logic [1:0]  rd_off;
	dmma_size_t  rd_size;
	logic [FIXED_RD_LAT-1:0] fix_pipe;
	logic [31:0] raw_rdata;
	logic        raw_valid;
	logic        issue;

	// Shared by all threads; reads in flight hold off issue, keeping their lane offset
	assign ld_ready_o = (state == DMMA_IDLE) && !fm_read_o && !(|fix_pipe);
	assign issue      = ld_req_i && ld_ready_o;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state           <= DMMA_IDLE;
			vm_pend         <= 1'b0;
			vm_read_o       <= 1'b0;
			vm_write_o      <= 1'b0;
			vm_address_o    <= 32'h0000_0000;
			vm_byteenable_o <= 4'h0;
			vm_writedata_o  <= 32'h0000_0000;
		end else begin
			case (state)
				DMMA_IDLE: begin
					if (issue && !to_fixed) begin
						state           <= DMMA_VWAIT;
						vm_pend         <= !ld_write_i;
						vm_read_o       <= !ld_write_i;
						vm_write_o      <= ld_write_i;
						vm_address_o    <= {phys_addr[31:2], 2'h0};
						vm_byteenable_o <= lane_be;
						vm_writedata_o  <= lane_wdata;
					end
				end
				DMMA_VWAIT: begin
					if ((vm_read_o || vm_write_o) && !vm_waitrequest_i) begin
						vm_read_o  <= 1'b0;
						vm_write_o <= 1'b0;
						if (vm_write_o) begin
							state <= DMMA_IDLE;
						end
					end
					if (vm_pend && vm_readdatavalid_i) begin
						vm_pend <= 1'b0;
						state   <= DMMA_IDLE;
					end
				end
				default: state <= DMMA_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fm_read_o       <= 1'b0;
			fm_write_o      <= 1'b0;
			fm_address_o    <= 32'h0000_0000;
			fm_byteenable_o <= 4'h0;
			fm_writedata_o  <= 32'h0000_0000;
			fix_pipe        <= '0;
		end else begin
			fm_read_o  <= issue && to_fixed && !ld_write_i;
			fm_write_o <= issue && to_fixed && ld_write_i;
			if (issue && to_fixed) begin
				fm_address_o    <= {phys_addr[31:2], 2'h0};
				fm_byteenable_o <= lane_be;
				fm_writedata_o  <= lane_wdata;
			end
			// Data is due exactly two edges after the read strobe
			fix_pipe <= {fm_read_o, fix_pipe[FIXED_RD_LAT-1:1]};
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_off  <= 2'h0;
			rd_size <= DMMA_SZ_WORD;
		end else if (issue && !ld_write_i) begin
			rd_off  <= phys_addr[1:0];
			rd_size <= ld_size_i;
		end
	end

	assign raw_valid = fix_pipe[0] || (vm_pend && vm_readdatavalid_i);
	assign raw_rdata = fix_pipe[0] ? fm_readdata_i : vm_readdata_i;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ld_valid_o <= 1'b0;
			ld_rdata_o <= 32'h0000_0000;
		end else begin
			ld_valid_o <= raw_valid;
			if (raw_valid) begin
				case (rd_size)
					DMMA_SZ_BYTE: ld_rdata_o <= {24'h000000, 8'(raw_rdata >> (5'd24 - 5'(rd_off) * 5'd8))};
					DMMA_SZ_HALF: ld_rdata_o <= {16'h0000, rd_off[1] ? raw_rdata[15:0] : raw_rdata[31:16]};
					default:      ld_rdata_o <= raw_rdata;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Thread information side port

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ti_thread_o             <= '0;
			ti_context_identifier_o <= '0;
			ti_valid_o              <= 1'b0;
		end else begin
			ti_valid_o <= issue;
			if (issue) begin
				ti_thread_o             <= ld_thread_i;
				ti_context_identifier_o <= ld_ctx_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	chk_fetch_msb_high: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) im_read_o |-> im_address_o[31])
		else $error("Fetch address top bit low");
	chk_data_msb_low: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		(fm_read_o || fm_write_o || vm_read_o || vm_write_o) |->
		(!fm_address_o[31] && !vm_address_o[31])) else $error("Data address top bit set");
	chk_fixed_two_cycle: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) fm_read_o |-> ##3 ld_valid_o)
		else $error("Fixed read not answered in time");
	chk_route_fixed: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (issue && to_fixed) |=>
		((fm_read_o || fm_write_o) && !vm_read_o && !vm_write_o))
		else $error("Fixed access misrouted");
	chk_route_var: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (issue && !to_fixed) |=>
		((vm_read_o || vm_write_o) && !fm_read_o && !fm_write_o))
		else $error("Variable access misrouted");
	chk_byte_lane: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		(issue && ld_size_i == DMMA_SZ_BYTE && phys_addr[1:0] == 2'h0) |=>
		(fm_byteenable_o == 4'h8 || vm_byteenable_o == 4'h8))
		else $error("Byte zero not on top lane");
	chk_ea_sum: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (issue && !THREAD_PART && !CTX_PART) |=>
		(((fm_read_o || fm_write_o) ? fm_address_o : vm_address_o) ==
		($past(ld_base_i + {{16{ld_imm_i[15]}}, ld_imm_i}) & 32'h7FFF_FFFC)))
		else $error("Effective address wrong");
	chk_side_port: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) issue |=> (ti_valid_o && ti_thread_o == $past(ld_thread_i)))
		else $error("Thread number not exported");
	chk_one_data_op: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (state == DMMA_VWAIT) |=> (!fm_read_o && !fm_write_o))
		else $error("Second data access overlapped");
endmodule

// *** dmma_mem_model.sv ***
`timescale 1ns/1ps
module dmma_mem_model (
	// Clock, reset and pacing
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        slow_i,
	// Instruction side
	input  wire logic        im_read_i,
	input  wire logic [31:0] im_address_i,
	output logic             im_waitrequest_o,
	output logic             im_readdatavalid_o,
	output logic [31:0]      im_readdata_o,
	// Fixed-latency side
	input  wire logic        fm_read_i,
	input  wire logic        fm_write_i,
	input  wire logic [31:0] fm_address_i,
	input  wire logic [3:0]  fm_byteenable_i,
	input  wire logic [31:0] fm_writedata_i,
	output logic [31:0]      fm_readdata_o,
	// Variable-latency side
	input  wire logic        vm_read_i,
	input  wire logic        vm_write_i,
	input  wire logic [31:0] vm_address_i,
	input  wire logic [3:0]  vm_byteenable_i,
	input  wire logic [31:0] vm_writedata_i,
	output logic             vm_waitrequest_o,
	output logic             vm_readdatavalid_o,
	output logic [31:0]      vm_readdata_o,
	// Observation
	output logic [31:0]      n_fm_o,
	output logic [31:0]      n_vm_o,
	output logic [31:0]      last_addr_o
);
	logic [31:0] mem [0:1023];
	logic        rd_p1;
	logic        v_pend;
	logic        v_acc;
	logic [31:0] a_p1;
	logic [31:0] v_addr;
	logic [1:0]  wcnt;
	function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] be);
		for (int i = 0; i < 4; i++) if (be[i]) o[8*i+:8] = n[8*i+:8];
		return o;
	endfunction
	////////////////////////////////////////////////////////////////
	// Stalls only when asked, so held requests get exercised
	// One store behind both data sides, so both data masters see one map; fetches never read it
	// Upper address bits alias; stimulus only uses words that map here
	assign vm_waitrequest_o = slow_i && (vm_read_i || vm_write_i) && (wcnt < 2'h2);
	assign v_acc            = (vm_read_i || vm_write_i) && !vm_waitrequest_o;
	assign im_waitrequest_o = 1'b0;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{rd_p1, v_pend, wcnt, im_readdatavalid_o, vm_readdatavalid_o} <= '0;
			{n_fm_o, n_vm_o, last_addr_o} <= '0;
			{im_readdata_o, fm_readdata_o, vm_readdata_o} <= '0;
		end else begin
			// Released data lines toggle instead of holding the last word
			im_readdatavalid_o <= im_read_i;
			im_readdata_o <= im_read_i ? im_address_i ^ 32'h5A5A_0000 : ~im_readdata_o;
			rd_p1 <= fm_read_i;
			a_p1 <= fm_address_i;
			fm_readdata_o <= rd_p1 ? mem[a_p1[11:2]] : ~fm_readdata_o;
			if (fm_write_i) mem[fm_address_i[11:2]] <= merge(mem[fm_address_i[11:2]],
				fm_writedata_i, fm_byteenable_i);
			if (fm_read_i || fm_write_i) begin
				n_fm_o <= n_fm_o + 32'h1;
				last_addr_o <= fm_address_i;
			end
			wcnt <= v_acc ? 2'h0 : wcnt + {1'b0, vm_waitrequest_o};
			v_pend <= v_acc && vm_read_i;
			v_addr <= vm_address_i;
			vm_readdatavalid_o <= v_pend;
			vm_readdata_o <= v_pend ? mem[v_addr[11:2]] : ~vm_readdata_o;
			if (v_acc) begin
				n_vm_o <= n_vm_o + 32'h1;
				last_addr_o <= vm_address_i;
				if (vm_write_i) mem[vm_address_i[11:2]] <= merge(mem[vm_address_i[11:2]],
					vm_writedata_i, vm_byteenable_i);
			end
		end
	end
endmodule

// *** dmma_core_test.sv ***
`timescale 1ns/1ps
module dmma_core_test;
	import dmma_pkg::*;
	logic ref_clk_i, reset_n_i, slow, if_req_i, ld_req_i, ld_write_i;
	logic [31:0] if_addr_i, ld_base_i, ld_wdata_i, n_fm, n_vm, last_addr;
	logic [15:0] ld_imm_i;
	dmma_size_t  ld_size_i;
	logic [2:0]  ld_thread_i;
	logic [5:0]  ld_ctx_i, ti_ctx;
	logic [2:0]  ti_thread;
	logic if_ready_o, if_valid_o, ld_ready_o, ld_valid_o, ti_valid;
	logic [31:0] if_data_o, ld_rdata_o;
	logic im_read, im_wr, im_rv, fm_read, fm_write, vm_read, vm_write, vm_wr, vm_rv;
	logic [31:0] im_addr, im_rd, fm_addr, fm_wd, fm_rd, vm_addr, vm_wd, vm_rd;
	logic [3:0]  fm_be, vm_be;
	logic        p_req, p_ready, p_fw, p_vw, p_vr;
	logic [31:0] p_fa, p_va;
	int n_mismatch = 0;
	int num_checks = 0;
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	dmma_core dmma_core_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.if_req_i(if_req_i), .if_addr_i(if_addr_i), .if_ready_o(if_ready_o),
		.if_valid_o(if_valid_o), .if_data_o(if_data_o), .ld_req_i(ld_req_i),
		.ld_write_i(ld_write_i), .ld_base_i(ld_base_i), .ld_imm_i(ld_imm_i),
		.ld_size_i(ld_size_i), .ld_wdata_i(ld_wdata_i), .ld_thread_i(ld_thread_i),
		.ld_ctx_i(ld_ctx_i), .ld_ready_o(ld_ready_o), .ld_valid_o(ld_valid_o),
		.ld_rdata_o(ld_rdata_o), .im_read_o(im_read), .im_address_o(im_addr),
		.im_waitrequest_i(im_wr), .im_readdatavalid_i(im_rv), .im_readdata_i(im_rd),
		.fm_read_o(fm_read), .fm_write_o(fm_write), .fm_address_o(fm_addr),
		.fm_byteenable_o(fm_be), .fm_writedata_o(fm_wd), .fm_readdata_i(fm_rd),
		.vm_read_o(vm_read), .vm_write_o(vm_write), .vm_address_o(vm_addr),
		.vm_byteenable_o(vm_be), .vm_writedata_o(vm_wd), .vm_waitrequest_i(vm_wr),
		.vm_readdatavalid_i(vm_rv), .vm_readdata_i(vm_rd), .ti_thread_o(ti_thread),
		.ti_context_identifier_o(ti_ctx), .ti_valid_o(ti_valid));
	dmma_mem_model dmma_mem_model_i (.clk_i(ref_clk_i), .rst_n_i(reset_n_i), .slow_i(slow),
		.im_read_i(im_read), .im_address_i(im_addr), .im_waitrequest_o(im_wr),
		.im_readdatavalid_o(im_rv), .im_readdata_o(im_rd), .fm_read_i(fm_read),
		.fm_write_i(fm_write), .fm_address_i(fm_addr), .fm_byteenable_i(fm_be),
		.fm_writedata_i(fm_wd), .fm_readdata_o(fm_rd), .vm_read_i(vm_read),
		.vm_write_i(vm_write), .vm_address_i(vm_addr), .vm_byteenable_i(vm_be),
		.vm_writedata_i(vm_wd), .vm_waitrequest_o(vm_wr), .vm_readdatavalid_o(vm_rv),
		.vm_readdata_o(vm_rd), .n_fm_o(n_fm), .n_vm_o(n_vm), .last_addr_o(last_addr));
	// Partitioned build, watched at its ready, address and write strobe outputs only
	dmma_core #(.THREAD_PART(1'b1), .CTX_PART(1'b1)) dmma_core_part_i (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.if_req_i(1'b0), .if_addr_i(if_addr_i), .if_ready_o(),
		.if_valid_o(), .if_data_o(), .ld_req_i(p_req),
		.ld_write_i(ld_write_i), .ld_base_i(ld_base_i), .ld_imm_i(ld_imm_i),
		.ld_size_i(ld_size_i), .ld_wdata_i(ld_wdata_i), .ld_thread_i(ld_thread_i),
		.ld_ctx_i(ld_ctx_i), .ld_ready_o(p_ready), .ld_valid_o(),
		.ld_rdata_o(), .im_read_o(), .im_address_o(),
		.im_waitrequest_i(1'b0), .im_readdatavalid_i(1'b0), .im_readdata_i(32'h0000_0000),
		.fm_read_o(), .fm_write_o(p_fw), .fm_address_o(p_fa),
		.fm_byteenable_o(), .fm_writedata_o(), .fm_readdata_i(fm_rd),
		.vm_read_o(p_vr), .vm_write_o(p_vw), .vm_address_o(p_va),
		.vm_byteenable_o(), .vm_writedata_o(), .vm_waitrequest_i(1'b0),
		.vm_readdatavalid_i(p_vr), .vm_readdata_i(vm_rd), .ti_thread_o(),
		.ti_context_identifier_o(), .ti_valid_o());
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(ref logic s, output int k);
		k = 1;
		while (s !== 1'b1) begin
			@(negedge ref_clk_i);
			k++;
			if (k > 60) begin
				n_mismatch++;
				$display("BAD %0t handshake never came", $time);
				wrap_up();
			end
		end
	endtask
	// One data access; lat of zero skips the latency count
	task automatic acc(input logic w, input logic [31:0] b, input logic [15:0] imm,
		input dmma_size_t sz, input logic [31:0] wd, input logic [31:0] rexp, input int lat);
		int k;
		{ld_write_i, ld_base_i, ld_imm_i, ld_size_i, ld_wdata_i} = {w, b, imm, sz, wd};
		ld_thread_i = ld_thread_i + 3'h1;
		ld_ctx_i = ld_ctx_i + 6'h5;
		ld_req_i = 1'b1;
		#1 wait_hi(ld_ready_o, k);
		@(negedge ref_clk_i);
		ld_req_i = 1'b0;
		chk({ti_valid, ti_thread, ti_ctx}, {1'b1, ld_thread_i, ld_ctx_i});
		if (!w) begin
			wait_hi(ld_valid_o, k);
			chk(ld_rdata_o, rexp);
			if (lat > 0) chk(32'(k), 32'(lat));
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_lanes();
		logic [31:0] w = 32'hA1B2C3D4;
		acc(1'b1, 32'h100, 16'h0, DMMA_SZ_WORD, 32'h1122_3344, 32'h0, 0);
		acc(1'b0, 32'h100, 16'h0, DMMA_SZ_WORD, 32'h0, 32'h1122_3344, 4);
		acc(1'b1, 32'h200, 16'h0, DMMA_SZ_WORD, w, 32'h0, 0);
		for (int i = 0; i < 4; i++)
			acc(1'b0, 32'h200 + i, 16'h0, DMMA_SZ_BYTE, 32'h0, (w >> (24 - 8 * i)) & 32'hFF, 4);
		for (int i = 0; i < 2; i++)
			acc(1'b0, 32'h200 + 2 * i, 16'h0, DMMA_SZ_HALF, 32'h0, (w >> (16 - 16 * i)) & 32'hFFFF, 4);
		acc(1'b1, 32'h201, 16'h0, DMMA_SZ_BYTE, 32'h5E, 32'h0, 0);
		acc(1'b1, 32'h202, 16'h0, DMMA_SZ_HALF, 32'h9988, 32'h0, 0);
		acc(1'b0, 32'h200, 16'h0, DMMA_SZ_WORD, 32'h0, 32'hA15E_9988, 4);
		$display("test lanes done");
	endtask
	task automatic t_route();
		logic [31:0] nv;
		logic [31:0] nf;
		slow = 1'b1;
		{nv, nf} = {n_vm, n_fm};
		acc(1'b1, 32'h8002_0800, 16'h0, DMMA_SZ_WORD, 32'hCAFE_0001, 32'h0, 0);
		acc(1'b0, 32'h0002_0800, 16'h0, DMMA_SZ_WORD, 32'h0, 32'hCAFE_0001, 0);
		chk(last_addr, 32'h0002_0800);
		chk(n_vm - nv, 32'h2);
		chk(n_fm - nf, 32'h0);
		slow = 1'b0;
		acc(1'b1, 32'h8000_0300, 16'h0, DMMA_SZ_WORD, 32'h0000_0077, 32'h0, 0);
		repeat (2) @(negedge ref_clk_i);
		chk(last_addr, 32'h0000_0300);
		acc(1'b1, 32'h3FC, 16'h0, DMMA_SZ_WORD, 32'h0BAD_F00D, 32'h0, 0);
		acc(1'b0, 32'h400, 16'hFFFC, DMMA_SZ_WORD, 32'h0, 32'h0BAD_F00D, 4);
		$display("test route done");
	endtask
	task automatic t_fetch(input logic [31:0] a);
		int k;
		logic [31:0] nd = n_fm + n_vm;
		if_addr_i = a;
		if_req_i = 1'b1;
		#1 wait_hi(if_ready_o, k);
		@(negedge ref_clk_i);
		if_req_i = 1'b0;
		wait_hi(if_valid_o, k);
		chk(if_data_o, (a | 32'h8000_0000) ^ 32'h5A5A_0000);
		chk(n_fm + n_vm, nd);
		$display("test fetch done");
	endtask
	// Thread offset outside the context window, context stride inside it
	task automatic t_part();
		int k;
		ld_write_i = 1'b1;
		ld_size_i = DMMA_SZ_WORD;
		ld_imm_i = 16'h0000;
		ld_base_i = 32'h0000_0080;
		ld_thread_i = 3'h3;
		p_req = 1'b1;
		#1 wait_hi(p_ready, k);
		@(negedge ref_clk_i);
		p_req = 1'b0;
		chk(p_fa, 32'h80 + 3 * THREAD_STRIDE_DEF);
		chk(32'(p_fw), 32'h1);
		ld_base_i = 32'h8010_0010;
		ld_ctx_i = 6'h5;
		p_req = 1'b1;
		#1 wait_hi(p_ready, k);
		@(negedge ref_clk_i);
		p_req = 1'b0;
		chk(p_va, CTX_BASE_DEF + 32'h10 + 5 * CTX_STRIDE_DEF);
		chk(32'(p_vw), 32'h1);
		$display("test partition done");
	endtask
	initial begin
		{reset_n_i, slow, if_req_i, ld_req_i, p_req, ld_write_i, if_addr_i, ld_base_i} = '0;
		{ld_wdata_i, ld_imm_i, ld_thread_i, ld_ctx_i} = '0;
		ld_size_i = DMMA_SZ_WORD;
		repeat (4) @(negedge ref_clk_i);
		reset_n_i = 1'b1;
		t_lanes();
		t_route();
		t_fetch(32'h0000_0040);
		t_fetch(32'h0000_1234);
		t_part();
		wrap_up();
	end
endmodule
